// *** inc/gst_consts.svh ***
// register offsets, field positions, reset values and codes of the gated timer
`ifndef GST_CONSTS_SVH
`define GST_CONSTS_SVH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define GST_OFF_CTRL      8'h00
`define GST_OFF_GATE      8'h04
`define GST_OFF_CNT_LOW   8'h08
`define GST_OFF_CNT_HIGH  8'h0C
`define GST_OFF_INT_STAT  8'h10
`define GST_OFF_INT_CLR   8'h14
`define GST_OFF_INT_EN    8'h18
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define GST_CTRL_ON       0
`define GST_CTRL_EXT      1
`define GST_CTRL_SYNCDIS  2
`define GST_CTRL_PS_LO    4
`define GST_CTRL_PS_HI    5
`define GST_GATE_SRC_LO   0
`define GST_GATE_SRC_HI   1
`define GST_GATE_CMPA_SYN 2
`define GST_GATE_CMPB_SYN 3
`define GST_GATE_POL      6
`define GST_GATE_EN       7
`define GST_INT_OVF       0
// -----------------------------------------------------------------
// reset values and codes
// -----------------------------------------------------------------
`define GST_CTRL_RST      8'h00
`define GST_GATE_RST      8'h00
`define GST_INT_RST       1'h0
`define GST_CNT_ZERO      16'h0000
`define GST_CNT_MAX       16'hFFFF
`define GST_CNT_ONE       16'h0001
`define GST_PRE_ZERO      3'h0
`define GST_PRE_ONE       3'h1
`define GST_PS_DIV1       2'h0
`define GST_PS_DIV2       2'h1
`define GST_PS_DIV4       2'h2
`define GST_PS_DIV8       2'h3
`define GST_MASK_DIV1     3'h0
`define GST_MASK_DIV2     3'h1
`define GST_MASK_DIV4     3'h3
`define GST_MASK_DIV8     3'h7
`define GST_SRC_PIN       2'h0
`define GST_SRC_OTHER     2'h1
`define GST_SRC_CMPA      2'h2
`define GST_SRC_CMPB      2'h3
`define GST_RDATA_ZERO    32'h0000_0000
`endif

// *** inc/gst_pkg.sv ***
// types shared by the gated timer modules
package gst_pkg;
  typedef enum logic [0:0] {
    GST_IDLE   = 1'b0,
    GST_ANSWER = 1'b1
  } gst_bus_state_type;
  typedef logic [1:0]  gst_sel_type;
  typedef logic [15:0] gst_count_type;
endpackage

// *** inc/gst_core_if.sv ***
// signals between the timer core and its prescaler and gate units
interface gst_core_if;
  logic       tick;
  logic       count_clear;
  logic [1:0] prescale_select;
  logic       ext_select;
  logic       sync_disable;
  logic       gate_enable;
  logic       gate_polarity;
  logic [1:0] gate_source_select;
  logic       comp_a_sync;
  logic       comp_b_sync;
  logic       gate_open;
  modport prescale (input prescale_select, ext_select, sync_disable, count_clear,
                    output tick);
  modport gate (input gate_enable, gate_polarity, gate_source_select,
                comp_a_sync, comp_b_sync, output gate_open);
  modport core (output prescale_select, ext_select, sync_disable, count_clear,
                gate_enable, gate_polarity, gate_source_select, comp_a_sync,
                comp_b_sync, input tick, gate_open);
endinterface

// *** logic/gst_prescaler.sv ***
// clock source edge detection and 1/2/4/8 prescale counter
`include "gst_consts.svh"
module gst_prescaler (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   clk_en,
  input  wire logic   counter_clock,
  gst_core_if.prescale cif
);
  import gst_pkg::*;
  logic       sync_q1_reg;
  logic       sync_q2_reg;
  logic       sync_prev_reg;
  logic       async_prev_reg;
  logic [2:0] pre_cnt_reg;
  logic [2:0] mask;
  logic       edge_seen;

  // -----------------------------------------------------------------
  // source edges
  // -----------------------------------------------------------------
  // the unsynchronised path is two stages shorter, so a mode change
  // can drop or repeat one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q1_reg    <= 1'b0;
      sync_q2_reg    <= 1'b0;
      sync_prev_reg  <= 1'b0;
      async_prev_reg <= 1'b0;
    end else if (clk_en) begin
      sync_q1_reg    <= counter_clock;
      sync_q2_reg    <= sync_q1_reg;
      sync_prev_reg  <= sync_q2_reg;
      async_prev_reg <= counter_clock;
    end
  end

  always_comb begin
    if (!cif.ext_select) begin
      edge_seen = 1'b1;
    end else if (cif.sync_disable) begin
      edge_seen = counter_clock && !async_prev_reg;
    end else begin
      edge_seen = sync_q2_reg && !sync_prev_reg;
    end
  end

  // -----------------------------------------------------------------
  // prescale counter
  // -----------------------------------------------------------------
  always_comb begin
    unique case (cif.prescale_select)
      `GST_PS_DIV1: mask = `GST_MASK_DIV1;
      `GST_PS_DIV2: mask = `GST_MASK_DIV2;
      `GST_PS_DIV4: mask = `GST_MASK_DIV4;
      `GST_PS_DIV8: mask = `GST_MASK_DIV8;
    endcase
  end

  assign cif.tick = edge_seen && ((pre_cnt_reg & mask) == mask) && !cif.count_clear;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= `GST_PRE_ZERO;
    end else if (clk_en) begin
      if (cif.count_clear) begin
        pre_cnt_reg <= `GST_PRE_ZERO;
      end else if (cif.tick) begin
        pre_cnt_reg <= `GST_PRE_ZERO;
      end else if (edge_seen) begin
        pre_cnt_reg <= pre_cnt_reg + `GST_PRE_ONE;
      end
    end
  end

  property p_div_wrap;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cif.tick |=> (pre_cnt_reg == `GST_PRE_ZERO);
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("prescaler not wrapped");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cif.count_clear |-> !cif.tick ##1 (pre_cnt_reg == `GST_PRE_ZERO);
  endproperty
  a_clear: assert property (p_clear) else $error("prescaler not cleared");

  property p_async_edge;
    @(posedge pclk) disable iff (!presetn)
      clk_en && $past(clk_en) && cif.ext_select && cif.sync_disable && $rose(counter_clock)
        |-> edge_seen;
  endproperty
  a_async_edge: assert property (p_async_edge) else $error("direct edge missed");
endmodule

// *** logic/gst_gate.sv ***
// gate source selection, polarity and optional comparator resampling
`include "gst_consts.svh"
module gst_gate (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic gate_input_pin,
  input  wire logic other_timer_overflow,
  input  wire logic comparator_a_output,
  input  wire logic comparator_b_output,
  gst_core_if.gate  cif
);
  import gst_pkg::*;
  logic cmp_a_reg;
  logic cmp_b_reg;
  logic cmp_a_level;
  logic cmp_b_level;
  logic src_level;
  logic gate_open_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a_reg <= 1'b0;
      cmp_b_reg <= 1'b0;
    end else if (clk_en) begin
      cmp_a_reg <= comparator_a_output;
      cmp_b_reg <= comparator_b_output;
    end
  end

  assign cmp_a_level = cif.comp_a_sync ? cmp_a_reg : comparator_a_output;
  assign cmp_b_level = cif.comp_b_sync ? cmp_b_reg : comparator_b_output;

  always_comb begin
    unique case (cif.gate_source_select)
      `GST_SRC_PIN:   src_level = gate_input_pin;
      `GST_SRC_OTHER: src_level = other_timer_overflow;
      `GST_SRC_CMPA:  src_level = cmp_a_level;
      `GST_SRC_CMPB:  src_level = cmp_b_level;
    endcase
  end

  // polarity applies after the mux, so every source gets both senses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_open_reg <= 1'b1;
    end else if (clk_en) begin
      gate_open_reg <= !cif.gate_enable || (src_level == cif.gate_polarity);
    end
  end
  assign cif.gate_open = gate_open_reg;

  property p_free;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !cif.gate_enable |=> cif.gate_open;
  endproperty
  a_free: assert property (p_free) else $error("gate closed while disabled");

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cif.gate_enable
        |=> (cif.gate_open == ($past(src_level) == $past(cif.gate_polarity)));
  endproperty
  a_polarity: assert property (p_polarity) else $error("gate polarity wrong");

  property p_other_src;
    @(posedge pclk) disable iff (!presetn)
      clk_en && cif.gate_enable && cif.gate_source_select == `GST_SRC_OTHER
        && cif.gate_polarity && other_timer_overflow |=> cif.gate_open;
  endproperty
  a_other_src: assert property (p_other_src) else $error("overflow source ignored");
endmodule

// *** logic/gst_timer.sv ***
// gated 16-bit timer with prescaler, byte-wide count access over apb
`include "gst_consts.svh"
module gst_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        counter_clock,
  input  wire logic        gate_input_pin,
  input  wire logic        other_timer_overflow,
  input  wire logic        comparator_a_output,
  input  wire logic        comparator_b_output,
  input  wire logic        sleep_mode,
  output logic             irq,
  output logic             wake_request
);
  import gst_pkg::*;

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  gst_bus_state_type bus_state_reg;
  gst_count_type     count_reg;
  gst_count_type     count_next;
  logic [7:0]        counter_control_reg;
  logic [7:0]        gate_control_reg;
  logic              int_status_reg;
  logic              int_enable_reg;
  logic              int_status_next;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              irq_reg;
  logic              wake_reg;
  logic [31:0]       rd_value;
  logic              addr_hit;
  logic              wr_take;
  logic              wr_ctrl;
  logic              wr_gate;
  logic              wr_low;
  logic              wr_high;
  logic              wr_iclr;
  logic              wr_ien;
  logic              run_ok;
  logic              inc;
  logic              wrap;

  gst_core_if cif ();

  // -----------------------------------------------------------------
  // configuration to the units
  // -----------------------------------------------------------------
  assign cif.prescale_select    = counter_control_reg[`GST_CTRL_PS_HI:`GST_CTRL_PS_LO];
  assign cif.ext_select         = counter_control_reg[`GST_CTRL_EXT];
  assign cif.sync_disable       = counter_control_reg[`GST_CTRL_SYNCDIS];
  assign cif.count_clear        = wr_low || wr_high;
  assign cif.gate_enable        = gate_control_reg[`GST_GATE_EN];
  assign cif.gate_polarity      = gate_control_reg[`GST_GATE_POL];
  assign cif.gate_source_select = gate_control_reg[`GST_GATE_SRC_HI:`GST_GATE_SRC_LO];
  assign cif.comp_a_sync        = gate_control_reg[`GST_GATE_CMPA_SYN];
  assign cif.comp_b_sync        = gate_control_reg[`GST_GATE_CMPB_SYN];

  gst_prescaler u_prescaler (
    .pclk          (pclk),
    .presetn       (presetn),
    .clk_en        (clk_en),
    .counter_clock (counter_clock),
    .cif           (cif.prescale)
  );

  gst_gate u_gate (
    .pclk                 (pclk),
    .presetn              (presetn),
    .clk_en               (clk_en),
    .gate_input_pin       (gate_input_pin),
    .other_timer_overflow (other_timer_overflow),
    .comparator_a_output  (comparator_a_output),
    .comparator_b_output  (comparator_b_output),
    .cif                  (cif.gate)
  );

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  // one wait state: pready rises in the cycle after the first access cycle
  always_comb begin
    addr_hit = 1'b1;
    rd_value = `GST_RDATA_ZERO;
    unique case (paddr)
      `GST_OFF_CTRL:     rd_value[7:0] = counter_control_reg;
      `GST_OFF_GATE:     rd_value[7:0] = gate_control_reg;
      `GST_OFF_CNT_LOW:  rd_value[7:0] = count_reg[7:0];
      `GST_OFF_CNT_HIGH: rd_value[7:0] = count_reg[15:8];
      `GST_OFF_INT_STAT: rd_value[`GST_INT_OVF] = int_status_reg;
      `GST_OFF_INT_CLR:  rd_value = `GST_RDATA_ZERO;
      `GST_OFF_INT_EN:   rd_value[`GST_INT_OVF] = int_enable_reg;
      default:           addr_hit = 1'b0;
    endcase
  end

  assign wr_take = clk_en && psel && penable && pwrite && pready_reg && addr_hit;
  assign wr_ctrl = wr_take && (paddr == `GST_OFF_CTRL);
  assign wr_gate = wr_take && (paddr == `GST_OFF_GATE);
  assign wr_low  = wr_take && (paddr == `GST_OFF_CNT_LOW);
  assign wr_high = wr_take && (paddr == `GST_OFF_CNT_HIGH);
  assign wr_iclr = wr_take && (paddr == `GST_OFF_INT_CLR);
  assign wr_ien  = wr_take && (paddr == `GST_OFF_INT_EN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_reg <= GST_IDLE;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      prdata_reg    <= `GST_RDATA_ZERO;
    end else if (clk_en) begin
      unique case (bus_state_reg)
        GST_IDLE: begin
          if (psel && penable) begin
            bus_state_reg <= GST_ANSWER;
            pready_reg    <= 1'b1;
            pslverr_reg   <= !addr_hit;
            prdata_reg    <= pwrite ? `GST_RDATA_ZERO : rd_value;
          end
        end
        GST_ANSWER: begin
          bus_state_reg <= GST_IDLE;
          pready_reg    <= 1'b0;
          pslverr_reg   <= 1'b0;
          prdata_reg    <= `GST_RDATA_ZERO;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_control_reg <= `GST_CTRL_RST;
    end else if (wr_ctrl) begin
      counter_control_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_control_reg <= `GST_GATE_RST;
    end else if (wr_gate) begin
      gate_control_reg <= pwdata[7:0];
    end
  end

  // -----------------------------------------------------------------
  // counter
  // -----------------------------------------------------------------
  // in sleep only the unsynchronised external source keeps running
  assign run_ok = counter_control_reg[`GST_CTRL_ON]
                  && (!sleep_mode || (cif.ext_select && cif.sync_disable));
  assign inc    = run_ok && cif.tick && cif.gate_open;
  assign wrap   = inc && (count_reg == `GST_CNT_MAX);

  // a byte write wins over a coinciding increment; software should stop
  // the counter first, else the pair may look torn
  always_comb begin
    count_next = count_reg;
    if (inc) begin
      count_next = count_reg + `GST_CNT_ONE;
    end
    if (wr_low) begin
      count_next = {count_reg[15:8], pwdata[7:0]};
    end
    if (wr_high) begin
      count_next = {pwdata[7:0], count_reg[7:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `GST_CNT_ZERO;
    end else if (clk_en) begin
      count_reg <= count_next;
    end
  end

  // -----------------------------------------------------------------
  // interrupt
  // -----------------------------------------------------------------
  // set beats clear in the same cycle so no overflow is lost
  always_comb begin
    int_status_next = int_status_reg;
    if (wr_iclr && pwdata[`GST_INT_OVF]) begin
      int_status_next = 1'b0;
    end
    if (wrap) begin
      int_status_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= `GST_INT_RST;
    end else if (clk_en) begin
      int_status_reg <= int_status_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable_reg <= `GST_INT_RST;
    end else if (wr_ien) begin
      int_enable_reg <= pwdata[`GST_INT_OVF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg  <= int_status_next && int_enable_reg;
      wake_reg <= int_status_next && int_enable_reg && sleep_mode;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign irq          = irq_reg;
  assign wake_request = wake_reg;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_at_top;
    clk_en && inc && !wr_low && !wr_high && count_reg == `GST_CNT_MAX;
  endsequence

  sequence s_wrapped;
    count_reg == `GST_CNT_ZERO && int_status_reg;
  endsequence

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      s_at_top |=> s_wrapped;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap or flag missing");

  property p_hold_closed;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !cif.gate_open && !wr_low && !wr_high |=> $stable(count_reg);
  endproperty
  a_hold_closed: assert property (p_hold_closed) else $error("count moved, gate shut");

  property p_count_open;
    @(posedge pclk) disable iff (!presetn)
      clk_en && inc && !wr_low && !wr_high
        |=> count_reg == $past(count_reg) + `GST_CNT_ONE;
  endproperty
  a_count_open: assert property (p_count_open) else $error("count did not step");

  property p_sleep_hold;
    @(posedge pclk) disable iff (!presetn)
      clk_en && sleep_mode && !(cif.ext_select && cif.sync_disable)
        && !wr_low && !wr_high |=> $stable(count_reg);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count ran in sleep");

  property p_read_low;
    @(posedge pclk) disable iff (!presetn)
      clk_en && bus_state_reg == GST_IDLE && psel && penable && !pwrite
        && paddr == `GST_OFF_CNT_LOW |=> pready && prdata[7:0] == $past(count_reg[7:0]);
  endproperty
  a_read_low: assert property (p_read_low) else $error("low byte read wrong");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      clk_en && int_status_reg && int_enable_reg && !wr_iclr && !wr_ien |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_byte_write;
    @(posedge pclk) disable iff (!presetn)
      wr_high |=> count_reg[15:8] == $past(pwdata[7:0]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("high byte not written");

  property p_low_write;
    @(posedge pclk) disable iff (!presetn)
      wr_low |=> count_reg[7:0] == $past(pwdata[7:0]);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low byte not written");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      clk_en && wrap |=> int_status_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow flag lost");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
      clk_en && wr_iclr && pwdata[`GST_INT_OVF] && !wrap |=> !int_status_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("overflow flag not cleared");

  property p_sleep_run;
    @(posedge pclk) disable iff (!presetn)
      clk_en && sleep_mode && cif.ext_select && cif.sync_disable && cif.tick && cif.gate_open
        && counter_control_reg[`GST_CTRL_ON] && !wr_low && !wr_high |=> !$stable(count_reg);
  endproperty
  a_sleep_run: assert property (p_sleep_run) else $error("count stopped in sleep");

  property p_wake_awake;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !sleep_mode |=> !wake_request;
  endproperty
  a_wake_awake: assert property (p_wake_awake) else $error("wake raised while awake");

  property p_answer_once;
    @(posedge pclk) disable iff (!presetn)
      clk_en && pready |=> !pready;
  endproperty
  a_answer_once: assert property (p_answer_once) else $error("pready held too long");
endmodule

// *** tb/gst_far_model.sv ***
// far-side model: external count clock and the four gate sources
module gst_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ext_on,
  input  wire logic level,
  output logic      counter_clock,
  output logic      gate_input_pin,
  output logic      other_timer_overflow,
  output logic      comparator_a_output,
  output logic      comparator_b_output
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg;
  // -----------------------------------------------------------------
  // count clock, still outside bursts so no stray edge leaks in
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg       <= 2'h0;
      counter_clock <= 1'b0;
    end else if (ext_on) begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3) counter_clock <= !counter_clock;
    end else begin
      counter_clock <= 1'b0;
    end
  end
  // all sources share one level so any selection sees the same gate
  assign gate_input_pin       = level;
  assign other_timer_overflow = level;
  assign comparator_a_output  = level;
  assign comparator_b_output  = level;
endmodule

// *** tb/tb_gst_timer.sv ***
// self-checking bench of the gated timer
`include "gst_consts.svh"
module tb_gst_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import gst_pkg::*;
  logic          pclk, presetn, clk_en, psel, penable, pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, rdv;
  logic          sleep_mode, ext_on, level, last_err;
  wire  [31:0]   prdata;
  wire           pready, pslverr, irq, wake_request;
  wire           cclk, gpin, oovf, cmpa, cmpb;
  gst_count_type cnt, ca, cb;
  int            errors, comparisons;
  gst_timer u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_clock(cclk), .gate_input_pin(gpin),
    .other_timer_overflow(oovf), .comparator_a_output(cmpa), .comparator_b_output(cmpb),
    .sleep_mode(sleep_mode), .irq(irq), .wake_request(wake_request));
  gst_far_model u_far (.pclk(pclk), .presetn(presetn), .ext_on(ext_on), .level(level),
    .counter_clock(cclk), .gate_input_pin(gpin), .other_timer_overflow(oovf),
    .comparator_a_output(cmpa), .comparator_b_output(cmpb));
  // -----------------------------------------------------------------
  // bus and compare helpers
  // -----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cnt_get();
    apb(1'b0, `GST_OFF_CNT_LOW, 32'h0);
    cnt[7:0] = rdv[7:0];
    apb(1'b0, `GST_OFF_CNT_HIGH, 32'h0);
    cnt[15:8] = rdv[7:0];
  endtask
  // software stops the counter before loading it
  task automatic stop_load(input logic [7:0] lo, input logic [7:0] hi);
    wr(`GST_OFF_CTRL, 32'h0);
    wr(`GST_OFF_CNT_LOW, {24'h0, lo});
    wr(`GST_OFF_CNT_HIGH, {24'h0, hi});
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rdv, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({rdv[30:0], last_err}, 32'h1);
  endtask
  task automatic t_prescale();
    for (int ps = 0; ps < 4; ps++) begin
      stop_load(8'h00, 8'h00);
      wr(`GST_OFF_CTRL, {26'h0, 2'(ps), 4'h1});
      repeat (64) @(posedge pclk);
      wr(`GST_OFF_CTRL, 32'h0);
      cnt_get();
      chk(32'(cnt >= (64 >> ps) && cnt <= (72 >> ps) + 1), 32'h1);
    end
    // clears closer than eight inputs keep a /8 count at zero
    stop_load(8'h00, 8'h00);
    wr(`GST_OFF_CTRL, 32'h31);
    repeat (4) wr(`GST_OFF_CNT_LOW, 32'h0);
    wr(`GST_OFF_CTRL, 32'h0);
    cnt_get();
    chk(32'(cnt), 32'h0);
  endtask
  task automatic t_gate();
    logic pol, act;
    for (int i = 0; i < 17; i++) begin
      pol = i[2];
      act = i[3] | i[4];
      level <= pol ^ !act;
      stop_load(8'h00, 8'h00);
      wr(`GST_OFF_GATE, {24'h0, !i[4], pol, 2'h0, pol, pol, 2'(i)});
      wr(`GST_OFF_CTRL, 32'h1);
      repeat (20) @(posedge pclk);
      wr(`GST_OFF_CTRL, 32'h0);
      cnt_get();
      chk(32'(cnt != 0), 32'(act));
    end
  endtask
  task automatic t_overflow();
    wr(`GST_OFF_INT_EN, 32'h1);
    stop_load(8'hFF, 8'hFF);
    wr(`GST_OFF_CTRL, 32'h1);
    wr(`GST_OFF_CTRL, 32'h0);
    cnt_get();
    chk(32'(cnt >= 1 && cnt <= 8), 32'h1);
    apb(1'b0, `GST_OFF_INT_STAT, 32'h0);
    chk({rdv[31:1], irq}, 32'h1);
    wr(`GST_OFF_INT_EN, 32'h0);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    wr(`GST_OFF_INT_EN, 32'h1);
    wr(`GST_OFF_INT_CLR, 32'h1);
    apb(1'b0, `GST_OFF_INT_STAT, 32'h0);
    chk({rdv[31:1], irq}, 32'h0);
    apb(1'b0, `GST_OFF_INT_CLR, 32'h0);
    chk(rdv, 32'h0);
  endtask
  task automatic t_ext();
    stop_load(8'h00, 8'h00);
    ext_on <= 1'b1;
    wr(`GST_OFF_CTRL, 32'h3);
    repeat (80) @(posedge pclk);
    cnt_get();
    ca = cnt;
    cnt_get();
    chk(32'(ca >= 8 && ca <= 12 && cnt >= ca && cnt <= ca + 1), 32'h1);
    sleep_mode <= 1'b1;
    cnt_get();
    ca = cnt;
    repeat (40) @(posedge pclk);
    cnt_get();
    chk(32'(cnt), 32'(ca));
    cb = cnt;
    wr(`GST_OFF_CTRL, 32'h7);
    repeat (40) @(posedge pclk);
    cnt_get();
    chk(32'(cnt >= cb + 4 && cnt <= cb + 7), 32'h1);
    wr(`GST_OFF_CTRL, 32'h6);
    wr(`GST_OFF_CNT_LOW, 32'hFF);
    wr(`GST_OFF_CNT_HIGH, 32'hFF);
    wr(`GST_OFF_CTRL, 32'h7);
    repeat (24) @(posedge pclk);
    chk({irq, wake_request}, 32'h3);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({irq, wake_request}, 32'h2);
    ext_on <= 1'b0;
    wr(`GST_OFF_CTRL, 32'h0);
    wr(`GST_OFF_INT_CLR, 32'h1);
  endtask
  // clock enable low freezes the count for thirty cycles
  task automatic t_freeze();
    stop_load(8'h00, 8'h00);
    wr(`GST_OFF_CTRL, 32'h1);
    clk_en <= 1'b0;
    repeat (30) @(posedge pclk);
    clk_en <= 1'b1;
    wr(`GST_OFF_CTRL, 32'h0);
    cnt_get();
    chk(32'(cnt >= 3 && cnt <= 6), 32'h1);
  endtask
  // -----------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = !pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_mode, ext_on, level} = 7'h00;
    clk_en = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    comparisons = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_prescale();
    t_gate();
    t_overflow();
    t_ext();
    t_freeze();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    conclude();
  end
endmodule
